// ===== rtl/tarsl_pkg.sv
// tarsl_pkg: constants and types of the triple converter result and status logic
// assumes one 50 MHz system clock and a one-cycle strobe register port
// Function
// - sinc3 16-bit results, 4 Hz to 8 kHz
// - attenuator switched only by high-voltage bit 7
// - voltage settled after three, chopped two conversions
// - temperature settles likewise after input switch
// - temperature input internal or external sensor
// - ground switch floats, direct or resistor
// - status bits 8 to 15 never interrupt
// - status bits 0 to 7 ORed into interrupt
// - each interrupt source has mask bit
// - current result read clears all ready bits
// - current off: voltage/temperature read clears all
// - core awake: no result overwrite while ready bit set
// - core asleep: results always take newest
// - out of range clamps, sets error flag
// - voltage ready set when result written
package tarsl_pkg;
    // timing
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int MOD_RATE_HZ = 500_000;
    localparam int MOD_DIV = CLK_FREQ_HZ / MOD_RATE_HZ;
    localparam int MOD_CNT_W = 7;
    localparam int MIN_RATE_HZ = 4;
    localparam int MAX_RATE_HZ = 8_000;
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 16;
    localparam int ACC_W = 52;
    localparam int DEC_W = 17;
    localparam int SHIFT_W = 6;
    localparam int NUM_CH = 3;
    // decimation bounds, rounded so the rate stays inside 4 Hz to 8 kHz
    localparam logic [DEC_W-1:0] DEC_MIN = DEC_W'((MOD_RATE_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ);
    localparam logic [DEC_W-1:0] DEC_MAX = DEC_W'(MOD_RATE_HZ / MIN_RATE_HZ);
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CUR_RES = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_VOLT_RES = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_TEMP_RES = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_HV_CFG = 8'h20;
    // channel indices, also the ready bit positions
    localparam int CH_CUR = 0;
    localparam int CH_VOLT = 1;
    localparam int CH_TEMP = 2;
    // field positions
    localparam int MODE_CHOP = 3;
    localparam int MODE_TEMP_EXT = 4;
    localparam int MODE_GND_RES = 6;
    localparam int CFG_GND_CONN = 7;
    localparam int HV_ATTEN = 7;
    localparam int ST_ERR_LSB = 12;
    localparam int FLT_SHIFT_LSB = 17;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] HV_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [DEC_W-1:0] DEC_RST = DEC_MIN;
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 6'h03;
    // conversions to the first settled result
    localparam logic [1:0] SETTLE_NOCHOP = 2'h3;
    localparam logic [1:0] SETTLE_CHOP = 2'h2;
    localparam logic [RES_W-1:0] FS_POS = 16'h7FFF;
    localparam logic [RES_W-1:0] FS_NEG = 16'h8000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tarsl_bus_req_t;

    typedef struct packed {
        logic err;
        logic [RES_W-1:0] val;
    } tarsl_result_t;
endpackage

// ===== rtl/tarsl_top.sv
// tarsl_top: sinc3 decimation, settling, result lock, status and interrupt
// assumes modulator bitstreams are synchronous to clk_in and sampled on the divider tick
`timescale 1ns/100ps
module tarsl_top
    import tarsl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // register port
    input wire tarsl_bus_req_t bus_in,
    output logic [DATA_W-1:0] rd_data_out,
    // analog front end
    input wire logic [NUM_CH-1:0] mod_bit_in,
    input wire logic core_sleep_in,
    output logic [NUM_CH-1:0] chan_en_out,
    output logic temp_ext_sel_out,
    output logic atten_en_out,
    output logic gnd_direct_out,
    output logic gnd_resistor_out,
    // interrupt
    output logic irq_out
);
    logic [7:0] mode_reg;
    logic [7:0] config_reg;
    logic [7:0] hv_cfg_reg;
    logic [7:0] mask_reg;
    logic [DEC_W-1:0] dec_len_reg;
    logic [SHIFT_W-1:0] shift_reg;
    logic [NUM_CH-1:0] ready_reg;
    logic [NUM_CH-1:0] err_reg;
    logic [RES_W-1:0] result_reg [NUM_CH];
    logic [MOD_CNT_W-1:0] mod_cnt_reg;
    logic [DEC_W-1:0] dec_cnt_reg;
    logic signed [ACC_W-1:0] int1_reg [NUM_CH];
    logic signed [ACC_W-1:0] int2_reg [NUM_CH];
    logic signed [ACC_W-1:0] int3_reg [NUM_CH];
    logic signed [ACC_W-1:0] dly1_reg [NUM_CH];
    logic signed [ACC_W-1:0] dly2_reg [NUM_CH];
    logic signed [ACC_W-1:0] dly3_reg [NUM_CH];
    logic [1:0] settle_reg [NUM_CH];
    logic [DATA_W-1:0] rd_data_next;
    logic [NUM_CH-1:0] ready_next;

    // saturate a filter word to 16 bits, flag when it had to
    function automatic tarsl_result_t clamp16(input logic signed [ACC_W-1:0] v);
        tarsl_result_t r;
        r.err = 1'b0;
        r.val = v[RES_W-1:0];
        if (!v[ACC_W-1] && (|v[ACC_W-2:RES_W-1]))
        begin
            r.err = 1'b1;
            r.val = FS_POS;
        end
        else if (v[ACC_W-1] && !(&v[ACC_W-2:RES_W-1]))
        begin
            r.err = 1'b1;
            r.val = FS_NEG;
        end
        return r;
    endfunction

    // register decode
    wire wr_status = bus_in.wr && (bus_in.addr == OFS_STATUS);
    wire wr_mask = bus_in.wr && (bus_in.addr == OFS_MASK);
    wire wr_mode = bus_in.wr && (bus_in.addr == OFS_MODE);
    wire wr_config = bus_in.wr && (bus_in.addr == OFS_CONFIG);
    wire wr_filter = bus_in.wr && (bus_in.addr == OFS_FILTER);
    wire wr_hv = bus_in.wr && (bus_in.addr == OFS_HV_CFG);
    wire rd_cur = bus_in.rd && (bus_in.addr == OFS_CUR_RES);
    wire rd_volt = bus_in.rd && (bus_in.addr == OFS_VOLT_RES);
    wire rd_temp = bus_in.rd && (bus_in.addr == OFS_TEMP_RES);
    wire [NUM_CH-1:0] chan_en = mode_reg[NUM_CH-1:0];
    wire chop_on = mode_reg[MODE_CHOP];

    wire [DEC_W-1:0] wdata_dec = bus_in.wdata[DEC_W-1:0];
    wire [DEC_W-1:0] dec_len_next = (wdata_dec < DEC_MIN) ? DEC_MIN :
                                    (wdata_dec > DEC_MAX) ? DEC_MAX : wdata_dec;
    wire [SHIFT_W-1:0] shift_next = bus_in.wdata[FLT_SHIFT_LSB +: SHIFT_W];

    wire temp_switch = wr_mode && (bus_in.wdata[MODE_TEMP_EXT] != mode_reg[MODE_TEMP_EXT]);
    wire [NUM_CH-1:0] restart = ~chan_en | {temp_switch, 2'h0};

    // shared modulator tick and decimation, the channels sample simultaneously
    wire mod_tick = (mod_cnt_reg == MOD_CNT_W'(MOD_DIV - 1));
    wire dec_tick = mod_tick && (dec_cnt_reg == dec_len_reg - 17'h00001);

    wire [1:0] settle_need = chop_on ? SETTLE_CHOP : SETTLE_NOCHOP;

    logic signed [ACC_W-1:0] comb1 [NUM_CH];
    logic signed [ACC_W-1:0] comb2 [NUM_CH];
    logic signed [ACC_W-1:0] comb3 [NUM_CH];
    tarsl_result_t res [NUM_CH];
    logic [NUM_CH-1:0] conv_valid;
    logic [NUM_CH-1:0] do_write;

    always_comb
    begin
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            comb1[ch] = int3_reg[ch] - dly1_reg[ch];
            comb2[ch] = comb1[ch] - dly2_reg[ch];
            comb3[ch] = comb2[ch] - dly3_reg[ch];
            res[ch] = clamp16(comb3[ch] >>> shift_reg);
            conv_valid[ch] = dec_tick && chan_en[ch] && !restart[ch]
                             && (settle_reg[ch] >= settle_need - 2'h1);
            // hold result while ready, unless the core sleeps
            do_write[ch] = conv_valid[ch] && (!ready_reg[ch] || core_sleep_in);
        end
    end

    wire clr_all = rd_cur || (!chan_en[CH_CUR] && (rd_volt || rd_temp));
    wire [NUM_CH-1:0] clr_w1c = wr_status ? bus_in.wdata[NUM_CH-1:0] : 3'h0;
    wire [NUM_CH-1:0] ready_clr = clr_all ? 3'h7 : clr_w1c;
    // a new result sets ready and wins over a clear in the same cycle
    assign ready_next = (ready_reg & ~ready_clr) | do_write;

    wire [15:0] status_view = {1'b0, err_reg, 9'h000, ready_reg};
    // only the masked low byte interrupts
    wire irq_next = |(status_view[7:0] & mask_reg);

    always_comb
    begin
        rd_data_next = 32'h00000000;
        if (bus_in.addr == OFS_STATUS)
            rd_data_next = {16'h0000, status_view};
        else if (bus_in.addr == OFS_MASK)
            rd_data_next = {24'h000000, mask_reg};
        else if (bus_in.addr == OFS_MODE)
            rd_data_next = {24'h000000, mode_reg};
        else if (bus_in.addr == OFS_CONFIG)
            rd_data_next = {24'h000000, config_reg};
        else if (bus_in.addr == OFS_CUR_RES)
            rd_data_next = {16'h0000, result_reg[CH_CUR]};
        else if (bus_in.addr == OFS_VOLT_RES)
            rd_data_next = {16'h0000, result_reg[CH_VOLT]};
        else if (bus_in.addr == OFS_TEMP_RES)
            rd_data_next = {16'h0000, result_reg[CH_TEMP]};
        else if (bus_in.addr == OFS_FILTER)
            rd_data_next = {9'h000, shift_reg, dec_len_reg};
        else if (bus_in.addr == OFS_HV_CFG)
            rd_data_next = {24'h000000, hv_cfg_reg};
        if (!bus_in.rd)
            rd_data_next = 32'h00000000;
    end

    // control registers
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mode_reg <= MODE_RST;
            config_reg <= CONFIG_RST;
            hv_cfg_reg <= HV_RST;
            mask_reg <= MASK_RST;
            dec_len_reg <= DEC_RST;
            shift_reg <= SHIFT_RST;
        end
        else
        begin
            if (wr_mode)
                mode_reg <= bus_in.wdata[7:0];
            if (wr_config)
                config_reg <= bus_in.wdata[7:0];
            if (wr_hv)
                hv_cfg_reg <= bus_in.wdata[7:0];
            if (wr_mask)
                mask_reg <= bus_in.wdata[7:0];
            if (wr_filter)
            begin
                dec_len_reg <= dec_len_next;
                shift_reg <= shift_next;
            end
        end
    end

    // divider and decimation counters
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mod_cnt_reg <= '0;
            dec_cnt_reg <= '0;
        end
        else
        begin
            mod_cnt_reg <= mod_tick ? '0 : mod_cnt_reg + 7'h01;
            if (dec_tick || wr_filter)
                dec_cnt_reg <= '0;
            else if (mod_tick)
                dec_cnt_reg <= dec_cnt_reg + 17'h00001;
        end
    end

    // sinc3 integrators and combs per channel
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                int1_reg[ch] <= '0;
                int2_reg[ch] <= '0;
                int3_reg[ch] <= '0;
                dly1_reg[ch] <= '0;
                dly2_reg[ch] <= '0;
                dly3_reg[ch] <= '0;
                settle_reg[ch] <= 2'h0;
            end
        end
        else
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                // restart empties the filter so settling counts from zero
                if (restart[ch])
                begin
                    int1_reg[ch] <= '0;
                    int2_reg[ch] <= '0;
                    int3_reg[ch] <= '0;
                    dly1_reg[ch] <= '0;
                    dly2_reg[ch] <= '0;
                    dly3_reg[ch] <= '0;
                    settle_reg[ch] <= 2'h0;
                end
                else if (mod_tick)
                begin
                    int1_reg[ch] <= int1_reg[ch] + (mod_bit_in[ch] ? 52'sd1 : -52'sd1);
                    int2_reg[ch] <= int2_reg[ch] + int1_reg[ch];
                    int3_reg[ch] <= int3_reg[ch] + int2_reg[ch];
                    if (dec_tick)
                    begin
                        dly1_reg[ch] <= int3_reg[ch];
                        dly2_reg[ch] <= comb1[ch];
                        dly3_reg[ch] <= comb2[ch];
                        if (settle_reg[ch] != SETTLE_NOCHOP)
                            settle_reg[ch] <= settle_reg[ch] + 2'h1;
                    end
                end
            end
        end
    end

    // results, ready and error flags
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ready_reg <= 3'h0;
            err_reg <= 3'h0;
            for (int ch = 0; ch < NUM_CH; ch++)
                result_reg[ch] <= '0;
        end
        else
        begin
            ready_reg <= ready_next;
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                if (do_write[ch])
                begin
                    result_reg[ch] <= res[ch].val;
                    err_reg[ch] <= res[ch].err;
                end
            end
        end
    end

    // outputs all registered
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rd_data_out <= '0;
            chan_en_out <= 3'h0;
            temp_ext_sel_out <= 1'b0;
            atten_en_out <= 1'b0;
            gnd_direct_out <= 1'b0;
            gnd_resistor_out <= 1'b0;
            irq_out <= 1'b0;
        end
        else
        begin
            rd_data_out <= rd_data_next;
            chan_en_out <= chan_en;
            temp_ext_sel_out <= mode_reg[MODE_TEMP_EXT];
            atten_en_out <= hv_cfg_reg[HV_ATTEN];
            // ground switch: both off means floating
            gnd_direct_out <= config_reg[CFG_GND_CONN] && !mode_reg[MODE_GND_RES];
            gnd_resistor_out <= config_reg[CFG_GND_CONN] && mode_reg[MODE_GND_RES];
            irq_out <= irq_next;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    chk_rate_bounds: assert property ((dec_len_reg >= DEC_MIN) && (dec_len_reg <= DEC_MAX))
        else $error("decimation length out of range");
    chk_atten_write: assert property (
        wr_hv |-> ##2 (atten_en_out == $past(bus_in.wdata[7], 2)))
        else $error("attenuator does not follow register");
    chk_volt_settle: assert property (
        do_write[CH_VOLT] |-> settle_reg[CH_VOLT] >= (chop_on ? 2'h1 : 2'h2))
        else $error("voltage result written before settling");
    chk_temp_switch: assert property (temp_switch |=> settle_reg[CH_TEMP] == 2'h0)
        else $error("temperature settling not restarted");
    chk_gnd_float: assert property (
        !config_reg[CFG_GND_CONN] |=> !gnd_direct_out && !gnd_resistor_out)
        else $error("ground switch not floating");
    chk_flag_no_irq: assert property ((status_view[7:0] & mask_reg) == 8'h00 |=> !irq_out)
        else $error("high status bits raised interrupt");
    chk_irq_level: assert property (irq_out == |($past(status_view[7:0]) & $past(mask_reg)))
        else $error("interrupt does not track masked status");
    chk_mask_gate: assert property (
        ready_reg != 3'h0 && (ready_reg & mask_reg[NUM_CH-1:0]) == 3'h0 |=> !irq_out)
        else $error("masked source raised interrupt");
    chk_cur_read_clr: assert property (rd_cur && do_write == 3'h0 |=> ready_reg == 3'h0)
        else $error("current read did not clear ready");
    chk_off_read_clr: assert property (
        !chan_en[CH_CUR] && (rd_volt || rd_temp) && do_write == 3'h0 |=> ready_reg == 3'h0)
        else $error("result read with current off did not clear");
    chk_result_hold: assert property (
        ready_reg[CH_VOLT] && !core_sleep_in |=> $stable(result_reg[CH_VOLT]))
        else $error("voltage result overwritten while ready");
    chk_sleep_update: assert property (
        conv_valid[CH_VOLT] && core_sleep_in |=> result_reg[CH_VOLT] == $past(res[CH_VOLT].val))
        else $error("sleep update missed");
    chk_clamp_flag: assert property (do_write[CH_VOLT] && res[CH_VOLT].err |=>
        err_reg[CH_VOLT] && (result_reg[CH_VOLT] == FS_POS || result_reg[CH_VOLT] == FS_NEG))
        else $error("out of range result not clamped");
    chk_ready_set: assert property (do_write[CH_VOLT] |=> ready_reg[CH_VOLT])
        else $error("voltage ready not set");

    cov_volt_write: cover property (do_write[CH_VOLT]);
    cov_clamp: cover property (do_write[CH_TEMP] && res[CH_TEMP].err);
    cov_irq: cover property (irq_out ##1 rd_cur ##2 !irq_out);
    cov_locked: cover property (conv_valid[CH_VOLT] && !do_write[CH_VOLT]);
endmodule

// ===== dv/tarsl_tb.sv
// tb: self-checking bench for the triple converter result and status logic
// assumes the register map of tarsl_pkg, one 50 MHz clock and the minimum decimation of 63
`timescale 1ns/100ps
module tb
    import tarsl_pkg::*;
;
    // one conversion period at the minimum decimation length
    localparam int CONV = 63 * MOD_DIV;
    logic clk_in;
    logic arst_n_in;
    tarsl_bus_req_t bus;
    logic [DATA_W-1:0] rd_data;
    logic [NUM_CH-1:0] mod_bits;
    logic core_sleep;
    logic [NUM_CH-1:0] chan_en;
    logic temp_ext;
    logic atten;
    logic gnd_d;
    logic gnd_r;
    logic irq;
    int errors;
    int compares;

    tarsl_top DUT (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .bus_in(bus),
        .rd_data_out(rd_data),
        .mod_bit_in(mod_bits),
        .core_sleep_in(core_sleep),
        .chan_en_out(chan_en),
        .temp_ext_sel_out(temp_ext),
        .atten_en_out(atten),
        .gnd_direct_out(gnd_d),
        .gnd_resistor_out(gnd_r),
        .irq_out(irq)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic end_of_test;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                          input string what);
        @(posedge clk_in);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk_in);
        bus.rd <= 1'b0;
        @(negedge clk_in);
        chk(rd_data & mask, exp, what);
    endtask

    // counts cycles until the interrupt shows, judged against a window
    task automatic wait_irq(input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < hi)
        begin
            @(negedge clk_in);
            n++;
        end
        chk({31'h0, (irq === 1'b1) && (n >= lo)}, 32'h1, what);
    endtask

    initial
    begin
        int i;
        errors = 0;
        compares = 0;
        bus = '0;
        mod_bits = 3'h7;
        core_sleep = 1'b0;
        arst_n_in = 1'b0;
        cycles(6);
        arst_n_in <= 1'b1;
        @(negedge clk_in);
        chk({24'h0, chan_en, temp_ext, atten, gnd_d, gnd_r, irq}, 32'h0, "outputs at reset");
        // register reset values, 0x24 is unmapped
        for (i = 0; i < 10; i++)
            rd_chk(8'(i * 4), 32'hFFFFFFFF, (i == 7) ? 32'h0006003F : 32'h0, "reset value");
        wr_reg(OFS_FILTER, 32'h00000001);
        rd_chk(OFS_FILTER, 32'h0001FFFF, 32'h0000003F, "rate low clamp");
        wr_reg(OFS_FILTER, 32'h0001E849);
        rd_chk(OFS_FILTER, 32'h0001FFFF, 32'h0001E848, "rate high clamp");
        wr_reg(OFS_FILTER, 32'h0000003F);
        for (i = 0; i < 4; i++)
        begin
            wr_reg(OFS_CONFIG, {24'h0, i[1], 7'h0});
            wr_reg(OFS_MODE, {25'h0, i[0], 6'h0});
            cycles(2);
            chk({30'h0, gnd_d, gnd_r}, {30'h0, i == 2, i == 3}, "ground switch");
        end
        wr_reg(OFS_HV_CFG, 32'h0000007F);
        cycles(2);
        chk({31'h0, atten}, 32'h0, "attenuator off");
        wr_reg(OFS_HV_CFG, 32'h00000080);
        cycles(2);
        chk({31'h0, atten}, 32'h1, "attenuator on");
        // voltage channel alone, no chop, full positive input saturates
        wr_reg(OFS_MASK, 32'h00000002);
        wr_reg(OFS_MODE, 32'h00000002);
        wait_irq(2 * CONV, 3 * CONV + 200, "voltage settle");
        chk({29'h0, chan_en}, 32'h2, "channel enables");
        rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h00002002, "ready and error");
        @(posedge clk_in);
        mod_bits <= 3'h0;
        // two conversions pass while ready is still set
        cycles(2 * CONV);
        rd_chk(OFS_VOLT_RES, 32'hFFFFFFFF, 32'h00007FFF, "locked result");
        rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h00002000, "voltage read clears");
        wait_irq(0, CONV + 200, "next voltage result");
        rd_chk(OFS_VOLT_RES, 32'hFFFFFFFF, 32'h00008000, "negative clamp");
        wr_reg(OFS_MASK, 32'h000000FF);
        cycles(3);
        chk({31'h0, irq}, 32'h0, "error bit silent");
        wait_irq(0, CONV + 200, "ready again");
        // core asleep: results keep moving although ready stays set
        @(posedge clk_in);
        core_sleep <= 1'b1;
        mod_bits <= 3'h7;
        wr_reg(OFS_FILTER, 32'h0028003F);
        cycles(3 * CONV + 200);
        rd_chk(OFS_VOLT_RES, 32'hFFFFFFFF, 32'h00000000, "newest while asleep");
        rd_chk(OFS_STATUS, 32'h00007000, 32'h00000000, "error cleared");
        @(posedge clk_in);
        core_sleep <= 1'b0;
        // all three channels, chop on
        wr_reg(OFS_MODE, 32'h00000000);
        wr_reg(OFS_STATUS, 32'h00000007);
        wr_reg(OFS_MASK, 32'h00000002);
        wr_reg(OFS_MODE, 32'h0000000F);
        wait_irq(CONV, 2 * CONV + 200, "chopped settle");
        rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h00000007, "all ready");
        wr_reg(OFS_MASK, 32'h00000000);
        cycles(2);
        chk({31'h0, irq}, 32'h0, "all masked");
        wr_reg(OFS_MASK, 32'h00000001);
        cycles(2);
        chk({31'h0, irq}, 32'h1, "one source unmasked");
        rd_chk(OFS_TEMP_RES, 32'hFFFFFFFF, 32'h00000000, "temperature read first");
        rd_chk(OFS_STATUS, 32'h00000007, 32'h00000007, "current on keeps ready");
        rd_chk(OFS_CUR_RES, 32'hFFFFFFFF, 32'h00000000, "current result");
        rd_chk(OFS_STATUS, 32'h00000007, 32'h00000000, "current read clears all");
        cycles(2);
        chk({31'h0, irq}, 32'h0, "interrupt drops");
        // temperature input switched to the external sensor
        wr_reg(OFS_MASK, 32'h00000004);
        wr_reg(OFS_MODE, 32'h0000001F);
        wait_irq(CONV, 2 * CONV + 200, "input switch settle");
        chk({31'h0, temp_ext}, 32'h1, "external sensor");
        end_of_test;
    end

    initial
    begin
        #(95000 * 20);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test;
    end
endmodule
